// ==== core/acal_defines.vh ====
// register map, field positions, reset values and load constants
`ifndef ACAL_DEFINES_VH
`define ACAL_DEFINES_VH

// register byte offsets
`define ACAL_OFS_SEQ_SETUP    8'h0c
`define ACAL_OFS_PAIR_A       8'h34
`define ACAL_OFS_PAIR_B       8'h38
`define ACAL_OFS_PAIR_C       8'h3c
`define ACAL_OFS_PAIR_D       8'h40
`define ACAL_OFS_PAIR_E       8'h44
`define ACAL_OFS_CAL_EN       8'h48
`define ACAL_OFS_STATUS       8'h4c

// sequence setup fields
`define ACAL_SEQ_DONE_BIT     17
`define ACAL_SEQ_EN_BIT       16
`define ACAL_SEQ_SEL_BIT      10
`define ACAL_SEQ_UMASK_HI     9
`define ACAL_SEQ_UMASK_LO     6
`define ACAL_SEQ_LMASK_HI     5
`define ACAL_SEQ_LMASK_LO     0

// reset values
`define ACAL_RST_SEQ_SETUP    32'h0000_0000
`define ACAL_RST_PAIR         32'h0000_0000
`define ACAL_RST_CAL_EN       10'h3ff

// coefficient layout inside a pair word
`define ACAL_ODD_GAIN_HI      31
`define ACAL_ODD_OFFS_HI      23
`define ACAL_EVEN_GAIN_HI     15
`define ACAL_EVEN_OFFS_HI     7

// channel and pair counts
`define ACAL_NUM_CH           10
`define ACAL_NUM_PAIRS        5
`define ACAL_SW_PAIRS         3

// fixed point: result scaled by 512 so gain/256 and offset/2 stay exact
`define ACAL_FRAC_BITS        9
`define ACAL_HSIZE_WORD       3'h2

`endif

// ==== core/acal_seq_cal.v ====
// converter sequence trigger setup and per-channel calibration with bus slave
//
// Notes on behaviour
// - read-only bit 17 shows the exceptional sequence has finished
// - bit 16 enable lets a trigger event start the sequence
// - bit 10 picks trigger: 0 timer interrupt, 1 charge pump clock
// - bits 9:6 mask channels 6 to 9, combinable
// - bits 5:0 mask channels 0 to 5, bit 0 is channel 0
// - setup bits 31:18 and 15:11 always read zero
// - setup register clears to zero on the type-3 reset
// - every channel has its own gain and offset coefficient
// - coefficients copied from non-volatile memory after reset before use
// - gain and offset are 8-bit two's complement
// - result is raw times (1 + gain/256) plus offset/2
// - software cannot write coefficients of channels 6 to 9
// - pair registers at 34..44 hex, two channels each, reset zero
// - calibration registers written only as whole aligned words; reads at an aligned address decode any size
// - odd channel gain 31:24 offset 23:16, even gain 15:8 offset 7:0
// - per-channel enable; cleared passes the raw value through
//
// Implementation choice: the AHB-Lite register port.

`include "acal_defines.vh"

// 16-entry buffer between the converter stream and the calibration stage
module acal_fifo #(
  parameter W = 14,
  parameter D = 16,
  parameter P = 4
) (
  // clock and reset
  input  wire         hclk,
  input  wire         hresetn,
  // fill side
  input  wire         in_valid,
  output reg          in_ready_r,
  input  wire [W-1:0] in_data,
  // drain side
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem [0:D-1];
  reg [P-1:0] wr_ptr_r;
  reg [P-1:0] rd_ptr_r;
  reg [P:0]   count_r;
  reg [P:0]   count_nxt;
  wire        push;
  wire        pop;

  assign out_valid = (count_r != {(P+1){1'b0}});
  assign out_data  = mem[rd_ptr_r];
  assign push      = in_valid && in_ready_r;
  assign pop       = out_valid && out_ready;

  always @*
  begin
    count_nxt = count_r;
    if (push && !pop)
      count_nxt = count_r + 1'b1;
    else if (pop && !push)
      count_nxt = count_r - 1'b1;
  end

  always @(posedge hclk)
  begin
    if (push)
      mem[wr_ptr_r] <= in_data;
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ptr_r   <= {P{1'b0}};
      rd_ptr_r   <= {P{1'b0}};
      count_r    <= {(P+1){1'b0}};
      in_ready_r <= 1'b1;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      count_r    <= count_nxt;
      // registered full so the ready port comes from a flop
      in_ready_r <= (count_nxt != D[P:0]);
    end
  end
endmodule

module acal_seq_cal #(
  parameter RAW_W = 10,
  parameter FIFO_D = 16,
  parameter FIFO_P = 4
) (
  // clock and reset
  input  wire             hclk,
  input  wire             hresetn,
  // ahb-lite slave
  input  wire             hsel,
  input  wire [31:0]      haddr,
  input  wire [1:0]       htrans,
  input  wire             hwrite,
  input  wire [2:0]       hsize,
  input  wire [31:0]      hwdata,
  input  wire             hready,
  output reg  [31:0]      hrdata,
  output reg              hreadyout,
  output reg              hresp,
  // type-3 reset request, clears the sequence setup only
  input  wire             type3_clear,
  // non-volatile coefficient source
  output reg              nvm_rd_req,
  output reg  [2:0]       nvm_rd_index,
  input  wire             nvm_rd_valid,
  input  wire [31:0]      nvm_rd_data,
  // sequence triggers
  input  wire             timer_unit_interrupt,
  input  wire             charge_pump_clock,
  // conversion requests to the converter
  output reg              conv_req,
  output reg  [3:0]       conv_chan,
  // raw sample stream in
  input  wire             raw_valid,
  output wire             raw_ready,
  input  wire [3:0]       raw_chan,
  input  wire [RAW_W-1:0] raw_sample,
  // corrected sample stream out
  output reg              corrected_valid,
  input  wire             corrected_ready,
  output reg  [3:0]       corrected_chan,
  output reg  [RAW_W-1:0] corrected_sample
);
  localparam AW = RAW_W + 12;
  localparam [AW-1:0] SAT_MAX = {{12{1'b0}}, {RAW_W{1'b1}}};
  localparam [1:0] LD_REQ  = 2'h0;
  localparam [1:0] LD_WAIT = 2'h1;
  localparam [1:0] LD_DONE = 2'h2;
  localparam [1:0] SQ_IDLE = 2'h0;
  localparam [1:0] SQ_SCAN = 2'h1;
  localparam [1:0] SQ_WAIT = 2'h2;

  function [RAW_W-1:0] calib_fn;
    input [RAW_W-1:0] raw;
    input [7:0]       channel_gain_coeff;
    input [7:0]       channel_offset_coeff;
    reg   [AW-1:0]    r;
    reg   [AW-1:0]    g;
    reg   [AW-1:0]    o;
    reg   [AW-1:0]    acc;
    begin
      r   = {{12{1'b0}}, raw};
      g   = {{(AW-8){channel_gain_coeff[7]}}, channel_gain_coeff};
      o   = {{(AW-8){channel_offset_coeff[7]}}, channel_offset_coeff};
      // scaled by 512: raw*512 + raw*gain*2 + offset*256
      acc = (r << `ACAL_FRAC_BITS) + ((r * g) << 1) + (o << (`ACAL_FRAC_BITS - 1));
      if (acc[AW-1])
        calib_fn = {RAW_W{1'b0}};
      else if ((acc >> `ACAL_FRAC_BITS) > SAT_MAX)
        calib_fn = {RAW_W{1'b1}};
      else
        calib_fn = acc[`ACAL_FRAC_BITS+RAW_W-1:`ACAL_FRAC_BITS];
    end
  endfunction

  // sequence setup, calibration enable and coefficient state
  reg                   seq_enable_r;
  reg                   timer_irq_source_r;
  reg [3:0]             upper_channel_mask_r;
  reg [5:0]             lower_channel_mask_r;
  reg                   sequence_done_flag_r;
  reg [`ACAL_NUM_CH-1:0] cal_en_r;
  reg [15:0]            coef_r [0:`ACAL_NUM_CH-1];
  // bus state
  reg                   dp_wr_r;
  reg [7:0]             dp_addr_r;
  reg                   rd_late_r;
  reg [7:0]             rd_addr_r;
  reg [7:0]             rd_sel;
  reg [31:0]            rd_val;
  // loader and sequencer state
  reg [1:0]             ld_state_r;
  reg                   loaded_r;
  reg [1:0]             sq_state_r;
  reg [3:0]             sq_idx_r;
  reg [9:0]             sq_mask_r;
  reg                   trig_prev_r;
  integer               i;

  wire       bus_acc = hsel && hready && htrans[1];
  wire       trig_now = timer_irq_source_r ? charge_pump_clock : timer_unit_interrupt;
  wire [9:0] chan_mask = {upper_channel_mask_r, lower_channel_mask_r};
  wire       raw_push = raw_valid && raw_ready;
  wire       sq_last = (sq_idx_r == 4'h9);

  // fifo between stream and correction
  wire             fifo_valid;
  wire [RAW_W+3:0] fifo_data;
  wire             stage_pop;
  wire [3:0]       f_chan = fifo_data[RAW_W+3:RAW_W];
  wire [RAW_W-1:0] f_raw  = fifo_data[RAW_W-1:0];

  // samples held back until coefficients are loaded
  assign stage_pop = fifo_valid && loaded_r && (!corrected_valid || corrected_ready);

  acal_fifo #(
    .W (RAW_W + 4),
    .D (FIFO_D),
    .P (FIFO_P)
  ) u_fifo (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .in_valid   (raw_valid),
    .in_ready_r (raw_ready),
    .in_data    ({raw_chan, raw_sample}),
    .out_valid  (fifo_valid),
    .out_ready  (stage_pop),
    .out_data   (fifo_data)
  );

  // read mux
  always @*
  begin
    rd_sel = rd_late_r ? rd_addr_r : haddr[7:0];
    rd_val = 32'h0000_0000;
    case (rd_sel)
      // done flag read-only, reserved bits zero
      `ACAL_OFS_SEQ_SETUP:
        rd_val = {14'h0000, sequence_done_flag_r, seq_enable_r, 5'h00,
                  timer_irq_source_r, upper_channel_mask_r, lower_channel_mask_r};
      `ACAL_OFS_PAIR_A: rd_val = {coef_r[1], coef_r[0]};
      `ACAL_OFS_PAIR_B: rd_val = {coef_r[3], coef_r[2]};
      `ACAL_OFS_PAIR_C: rd_val = {coef_r[5], coef_r[4]};
      `ACAL_OFS_PAIR_D: rd_val = {coef_r[7], coef_r[6]};
      `ACAL_OFS_PAIR_E: rd_val = {coef_r[9], coef_r[8]};
      `ACAL_OFS_CAL_EN: rd_val = {22'h00_0000, cal_en_r};
      `ACAL_OFS_STATUS: rd_val = {30'h0000_0000, (sq_state_r != SQ_IDLE), loaded_r};
      default:          rd_val = 32'h0000_0000;
    endcase
  end

  // ahb-lite slave: zero wait, one wait on a read right after a write
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr_r   <= 1'b0;
      dp_addr_r <= 8'h00;
      rd_late_r <= 1'b0;
      rd_addr_r <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hresp <= 1'b0;
      // only whole aligned words are written
      dp_wr_r   <= bus_acc && hwrite && (hsize == `ACAL_HSIZE_WORD) && (haddr[1:0] == 2'h0);
      if (bus_acc)
        dp_addr_r <= haddr[7:0];
      if (rd_late_r)
      begin
        hrdata    <= rd_val;
        hreadyout <= 1'b1;
        rd_late_r <= 1'b0;
      end
      else if (bus_acc && !hwrite)
      begin
        // a write lands this cycle; sample registers one edge later
        if (dp_wr_r)
        begin
          rd_late_r <= 1'b1;
          rd_addr_r <= haddr[7:0];
          hreadyout <= 1'b0;
        end
        else
          hrdata <= rd_val;
      end
    end
  end

  // sequence setup and calibration enable registers
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      seq_enable_r         <= 1'b0;
      timer_irq_source_r   <= 1'b0;
      upper_channel_mask_r <= 4'h0;
      lower_channel_mask_r <= 6'h00;
      cal_en_r             <= `ACAL_RST_CAL_EN;
    end
    else if (type3_clear)
    begin
      seq_enable_r         <= 1'b0;
      timer_irq_source_r   <= 1'b0;
      upper_channel_mask_r <= 4'h0;
      lower_channel_mask_r <= 6'h00;
    end
    else if (dp_wr_r)
    begin
      if (dp_addr_r == `ACAL_OFS_SEQ_SETUP)
      begin
        seq_enable_r         <= hwdata[`ACAL_SEQ_EN_BIT];
        timer_irq_source_r   <= hwdata[`ACAL_SEQ_SEL_BIT];
        upper_channel_mask_r <= hwdata[`ACAL_SEQ_UMASK_HI:`ACAL_SEQ_UMASK_LO];
        lower_channel_mask_r <= hwdata[`ACAL_SEQ_LMASK_HI:`ACAL_SEQ_LMASK_LO];
      end
      if (dp_addr_r == `ACAL_OFS_CAL_EN)
        cal_en_r <= hwdata[`ACAL_NUM_CH-1:0];
    end
  end

  // coefficients: loader and software
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      // one coefficient pair per channel, zero at reset
      for (i = 0; i < `ACAL_NUM_CH; i = i + 1)
        coef_r[i] <= 16'h0000;
    end
    else if (ld_state_r == LD_WAIT && nvm_rd_valid)
    begin
      // copy pair word from non-volatile memory
      coef_r[{nvm_rd_index, 1'b0}] <= nvm_rd_data[`ACAL_EVEN_GAIN_HI:0];
      coef_r[{nvm_rd_index, 1'b1}] <= nvm_rd_data[`ACAL_ODD_GAIN_HI:16];
    end
    else if (dp_wr_r)
    begin
      // pairs d and e ignore software writes
      case (dp_addr_r)
        `ACAL_OFS_PAIR_A:
        begin
          coef_r[0] <= hwdata[15:0];
          coef_r[1] <= hwdata[31:16];
        end
        `ACAL_OFS_PAIR_B:
        begin
          coef_r[2] <= hwdata[15:0];
          coef_r[3] <= hwdata[31:16];
        end
        `ACAL_OFS_PAIR_C:
        begin
          coef_r[4] <= hwdata[15:0];
          coef_r[5] <= hwdata[31:16];
        end
        default:
        begin
        end
      endcase
    end
  end

  // loader fetches the five pair words once after reset
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ld_state_r   <= LD_REQ;
      loaded_r     <= 1'b0;
      nvm_rd_req   <= 1'b0;
      nvm_rd_index <= 3'h0;
    end
    else
    begin
      nvm_rd_req <= 1'b0;
      case (ld_state_r)
        LD_REQ:
        begin
          nvm_rd_req <= 1'b1;
          ld_state_r <= LD_WAIT;
        end
        LD_WAIT:
        begin
          if (nvm_rd_valid)
          begin
            if (nvm_rd_index == `ACAL_NUM_PAIRS - 1)
            begin
              ld_state_r <= LD_DONE;
              loaded_r   <= 1'b1;
            end
            else
            begin
              nvm_rd_index <= nvm_rd_index + 1'b1;
              ld_state_r   <= LD_REQ;
            end
          end
        end
        LD_DONE:
          loaded_r <= 1'b1;
        default:
          ld_state_r <= LD_REQ;
      endcase
    end
  end

  // exceptional sequence: trigger, channel walk, completion
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sq_state_r           <= SQ_IDLE;
      sq_idx_r             <= 4'h0;
      sq_mask_r            <= 10'h000;
      trig_prev_r          <= 1'b0;
      sequence_done_flag_r <= 1'b0;
      conv_req             <= 1'b0;
      conv_chan            <= 4'h0;
    end
    else
    begin
      trig_prev_r <= trig_now;
      conv_req    <= 1'b0;
      case (sq_state_r)
        SQ_IDLE:
        begin
          if (type3_clear)
            sequence_done_flag_r <= 1'b0;
          // rising edge of selected source starts it when enabled
          else if (seq_enable_r && trig_now && !trig_prev_r)
          begin
            sequence_done_flag_r <= 1'b0;
            sq_mask_r            <= chan_mask;
            sq_idx_r             <= 4'h0;
            sq_state_r           <= SQ_SCAN;
          end
        end
        SQ_SCAN:
        begin
          // masked channels converted in ascending order
          if (sq_mask_r[sq_idx_r])
          begin
            conv_req   <= 1'b1;
            conv_chan  <= sq_idx_r;
            sq_state_r <= SQ_WAIT;
          end
          else if (sq_last)
          begin
            sequence_done_flag_r <= 1'b1;
            sq_state_r           <= SQ_IDLE;
          end
          else
            sq_idx_r <= sq_idx_r + 1'b1;
        end
        SQ_WAIT:
        begin
          if (raw_push && raw_chan == sq_idx_r)
          begin
            if (sq_last)
            begin
              sequence_done_flag_r <= 1'b1;
              sq_state_r           <= SQ_IDLE;
            end
            else
            begin
              sq_idx_r   <= sq_idx_r + 1'b1;
              sq_state_r <= SQ_SCAN;
            end
          end
        end
        default:
          sq_state_r <= SQ_IDLE;
      endcase
    end
  end

  // correction stage
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      corrected_valid  <= 1'b0;
      corrected_chan   <= 4'h0;
      corrected_sample <= {RAW_W{1'b0}};
    end
    else if (stage_pop)
    begin
      corrected_valid <= 1'b1;
      corrected_chan  <= f_chan;
      // bypass when disabled; out-of-range channel passes raw
      if (f_chan < `ACAL_NUM_CH && cal_en_r[f_chan])
        corrected_sample <= calib_fn(f_raw, coef_r[f_chan][15:8], coef_r[f_chan][7:0]);
      else
        corrected_sample <= f_raw;
    end
    else if (corrected_ready)
      corrected_valid <= 1'b0;
  end
endmodule

// ==== verif/acal_seq_cal_assertions.sv ====
// port-level assertions for the sequence setup and calibration block
module acal_seq_cal_assertions #(
  parameter RAW_W = 10
) (
  // clock, reset and register bus
  input wire             hclk,
  input wire             hresetn,
  input wire             hsel,
  input wire [31:0]      haddr,
  input wire [1:0]       htrans,
  input wire             hwrite,
  input wire [2:0]       hsize,
  input wire [31:0]      hwdata,
  input wire             hready,
  input wire [31:0]      hrdata,
  input wire             hreadyout,
  input wire             hresp,
  // loader, triggers and converter requests
  input wire             type3_clear,
  input wire             nvm_rd_req,
  input wire [2:0]       nvm_rd_index,
  input wire             nvm_rd_valid,
  input wire [31:0]      nvm_rd_data,
  input wire             timer_unit_interrupt,
  input wire             charge_pump_clock,
  input wire             conv_req,
  input wire [3:0]       conv_chan,
  // sample streams
  input wire             raw_valid,
  input wire             raw_ready,
  input wire [3:0]       raw_chan,
  input wire [RAW_W-1:0] raw_sample,
  input wire             corrected_valid,
  input wire             corrected_ready,
  input wire [3:0]       corrected_chan,
  input wire [RAW_W-1:0] corrected_sample
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // pair words seen since reset; output must wait for all five
  reg [2:0] load_cnt_r;
  wire [2:0] load_cnt_nxt = (nvm_rd_valid && load_cnt_r < 3'h5) ? load_cnt_r + 3'h1 : load_cnt_r;
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      load_cnt_r <= 3'h0;
    else
      load_cnt_r <= load_cnt_nxt;

  sequence s_wr_take;
    hsel && hready && htrans[1] && hwrite;
  endsequence
  sequence s_rd_setup;
    hsel && hready && htrans[1] && !hwrite && haddr[7:0] == 8'h0c;
  endsequence

  a_bus_always_okay: assert property (hresp == 1'h0)
    else $error("bus response not okay");
  a_write_no_wait: assert property (s_wr_take |=> hreadyout)
    else $error("write stalled the bus");
  a_setup_reserved_zero: assert property (s_rd_setup |=> ##[0:1]
    (hreadyout && hrdata[31:18] == 14'h0 && hrdata[15:11] == 5'h0))
    else $error("reserved setup bits read nonzero");
  a_conv_single_pulse: assert property (conv_req |=> !conv_req)
    else $error("conversion request longer than one cycle");
  a_conv_chan_valid: assert property (conv_req |-> conv_chan <= 4'h9)
    else $error("conversion requested for missing channel");
  a_nvm_req_pulse: assert property (nvm_rd_req |=> !nvm_rd_req)
    else $error("coefficient request longer than one cycle");
  a_nvm_index_range: assert property (nvm_rd_req |-> nvm_rd_index <= 3'h4)
    else $error("coefficient request beyond last pair");
  a_no_early_output: assert property (corrected_valid |-> load_cnt_r == 3'h5)
    else $error("corrected sample before coefficients loaded");
  a_output_holds: assert property (corrected_valid && !corrected_ready |=>
    corrected_valid && $stable(corrected_sample) && $stable(corrected_chan))
    else $error("corrected sample changed while stalled");
endmodule

bind acal_seq_cal acal_seq_cal_assertions #(.RAW_W(RAW_W)) acal_seq_cal_assertions_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .type3_clear(type3_clear),
  .nvm_rd_req(nvm_rd_req), .nvm_rd_index(nvm_rd_index), .nvm_rd_valid(nvm_rd_valid),
  .nvm_rd_data(nvm_rd_data), .timer_unit_interrupt(timer_unit_interrupt),
  .charge_pump_clock(charge_pump_clock), .conv_req(conv_req), .conv_chan(conv_chan),
  .raw_valid(raw_valid), .raw_ready(raw_ready), .raw_chan(raw_chan),
  .raw_sample(raw_sample), .corrected_valid(corrected_valid),
  .corrected_ready(corrected_ready), .corrected_chan(corrected_chan),
  .corrected_sample(corrected_sample));

// ==== verif/acal_seq_cal_tb.sv ====
// self-checking bench for the sequence setup and calibration block
`include "acal_defines.vh"
`define CHK(nm, ex, ac) \
  begin \
    cmp_count++; \
    if ((ac) !== (ex)) \
    begin \
      miscompares++; \
      $display("unexpected %s expected %h seen %h", nm, ex, ac); \
    end \
  end

module acal_seq_cal_tb;
  timeunit 1ns;
  timeprecision 1ps;
  int          miscompares = 0, cmp_count = 0, nconv = 0, acc;
  logic        hclk = 1'h0, hresetn = 1'h0, hsel = 1'h1, hwrite = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, nvm_rd_data = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2, nvm_dly = 3'h0;
  logic        type3_clear = 1'h0, nvm_rd_valid = 1'h0, nvm_go = 1'h0;
  logic        timer_unit_interrupt = 1'h0, charge_pump_clock = 1'h0;
  logic        raw_valid = 1'h0, corrected_ready = 1'h1;
  logic [3:0]  raw_chan = 4'h0;
  logic [9:0]  raw_sample = 10'h0, calen = `ACAL_RST_CAL_EN;
  logic [31:0] nvm_tab [5] = '{32'h807f_7f81, 32'h10f0_c020, 32'h0102_0304,
                               32'h7f7f_8080, 32'hff01_01ff};
  logic [31:0] model [5];
  logic [13:0] expq [$], ev;
  wire  [31:0] hrdata;
  wire  [3:0]  conv_chan, corrected_chan;
  wire  [2:0]  nvm_rd_index;
  wire  [9:0]  corrected_sample;
  wire         hreadyout, hresp, nvm_rd_req, conv_req, raw_ready, corrected_valid;
  wire         hready = hreadyout;

  acal_seq_cal acal_seq_cal_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .type3_clear(type3_clear),
    .nvm_rd_req(nvm_rd_req), .nvm_rd_index(nvm_rd_index), .nvm_rd_valid(nvm_rd_valid),
    .nvm_rd_data(nvm_rd_data), .timer_unit_interrupt(timer_unit_interrupt),
    .charge_pump_clock(charge_pump_clock), .conv_req(conv_req), .conv_chan(conv_chan),
    .raw_valid(raw_valid), .raw_ready(raw_ready), .raw_chan(raw_chan),
    .raw_sample(raw_sample), .corrected_valid(corrected_valid),
    .corrected_ready(corrected_ready), .corrected_chan(corrected_chan),
    .corrected_sample(corrected_sample));

  always #5 hclk = ~hclk;

  // non-volatile source answers three cycles after each request, once released
  always @(posedge hclk)
  begin
    nvm_rd_valid <= nvm_go && nvm_dly == 3'h1;
    nvm_rd_data <= (nvm_go && nvm_dly == 3'h1) ? nvm_tab[nvm_rd_index] : ~nvm_rd_data;
    if (nvm_rd_req === 1'h1)
      nvm_dly <= 3'h3;
    else if (nvm_go && nvm_dly != 3'h0)
      nvm_dly <= nvm_dly - 3'h1;
  end

  always @(posedge hclk)
    if (conv_req === 1'h1)
      nconv++;

  // every corrected sample against the model
  always @(posedge hclk)
    if (corrected_valid === 1'h1 && corrected_ready === 1'h1)
    begin
      ev = expq.size() != 0 ? expq.pop_front() : 14'h0;
      `CHK("corrected sample", ev, {corrected_chan, corrected_sample})
    end

  function automatic logic [13:0] expv(input int ch, input int raw);
    logic [15:0] w;
    int r;
    if (ch > 9 || !calen[ch])
      return {4'(ch), 10'(raw)};
    w = ch[0] ? model[ch / 2][31:16] : model[ch / 2][15:0];
    // floor of the scaled sum, then clamp instead of wrapping
    r = (raw * 512 + raw * $signed(w[15:8]) * 2 + $signed(w[7:0]) * 256) >>> 9;
    r = r < 0 ? 0 : (r > 1023 ? 1023 : r);
    return {4'(ch), 10'(r)};
  endfunction

  task automatic bwr(input logic [7:0] a, input logic [31:0] wd, input logic [2:0] sz);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'h1;
    hsize <= sz;
    @(posedge hclk iff hreadyout === 1'h1);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk iff hreadyout === 1'h1);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= 1'h0;
    hsize <= `ACAL_HSIZE_WORD;
    @(posedge hclk iff hreadyout === 1'h1);
    htrans <= 2'h0;
    @(posedge hclk iff hreadyout === 1'h1);
    `CHK($sformatf("register %h", a), e, hrdata)
  endtask

  task automatic poll(input logic [7:0] a, input int b);
    logic [31:0] rd;
    rd = 32'h0;
    for (int i = 0; i < 60 && rd[b] !== 1'h1; i++)
    begin
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= 1'h0;
      @(posedge hclk iff hreadyout === 1'h1);
      htrans <= 2'h0;
      @(posedge hclk iff hreadyout === 1'h1);
      rd = hrdata;
    end
    `CHK($sformatf("bit %0d of %h", b, a), 1'h1, rd[b])
  endtask

  task automatic push(input int ch, input int v);
    raw_chan <= 4'(ch);
    raw_sample <= 10'(v);
    raw_valid <= 1'h1;
    @(posedge hclk iff raw_ready === 1'h1);
    expq.push_back(expv(ch, v));
  endtask

  task automatic drain();
    for (int i = 0; i < 300 && (expq.size() != 0 || corrected_valid !== 1'h0); i++)
      @(posedge hclk);
    `CHK("pending samples", 0, expq.size())
  endtask

  task automatic trig(input logic s);
    if (s)
      charge_pump_clock <= 1'h1;
    else
      timer_unit_interrupt <= 1'h1;
    @(posedge hclk);
    // only the pin just raised is lowered, so a following call never drives it twice
    if (s)
      charge_pump_clock <= 1'h0;
    else
      timer_unit_interrupt <= 1'h0;
  endtask

  task automatic conv(input int ch);
    @(posedge hclk iff conv_req === 1'h1);
    `CHK("conversion channel", 4'(ch), conv_chan)
    push(ch, 100 + ch);
    raw_valid <= 1'h0;
  endtask

  task automatic t3();
    type3_clear <= 1'h1;
    @(posedge hclk);
    type3_clear <= 1'h0;
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    #300000;
    miscompares++;
    report_and_stop();
  end

  initial
  begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'h1;
    @(posedge hclk);
    rchk(8'h0c, 32'h0);
    for (int i = 0; i < 5; i++) rchk(8'(52 + 4 * i), 32'h0);
    rchk(8'h48, 32'(`ACAL_RST_CAL_EN));
    rchk(8'h50, 32'h0);
    nvm_go <= 1'h1;
    poll(8'h4c, 0);
    for (int i = 0; i < 5; i++) rchk(8'(52 + 4 * i), nvm_tab[i]);
    model = nvm_tab;
    bwr(8'h34, 32'h0c40_f380, 3'h2);
    model[0] = 32'h0c40_f380;
    bwr(8'h40, 32'h1234_5678, 3'h2);
    bwr(8'h44, 32'h1234_5678, 3'h2);
    bwr(8'h38, 32'h1234_5678, 3'h0);
    bwr(8'h3a, 32'h1234_5678, 3'h2);
    for (int i = 0; i < 5; i++) rchk(8'(52 + 4 * i), model[i]);
    // all channels plus one out-of-range channel at zero, mid-scale and full scale, back to back
    for (int c = 0; c < 11; c++)
      for (int k = 0; k < 3; k++)
        push(c == 10 ? 12 : c, k * 511 + (k == 2));
    raw_valid <= 1'h0;
    drain();
    bwr(8'h48, 32'h155, 3'h2);
    calen = 10'h155;
    rchk(8'h48, 32'h155);
    for (int c = 0; c < 10; c++) push(c, 700);
    raw_valid <= 1'h0;
    drain();
    bwr(8'h48, 32'h3ff, 3'h2);
    calen = 10'h3ff;
    // buffer filled with the far side stalled
    corrected_ready <= 1'h0;
    for (acc = 0; acc < 24; acc++)
    begin
      raw_sample <= 10'(acc * 40);
      raw_chan <= 4'h3;
      raw_valid <= 1'h1;
      @(posedge hclk);
      if (raw_ready !== 1'h1)
        break;
      expq.push_back(expv(3, acc * 40));
    end
    `CHK("buffer depth", 1'h1, acc >= 16 && acc <= 18)
    repeat (4) @(posedge hclk);
    `CHK("refused when full", 1'h0, raw_ready)
    corrected_ready <= 1'h1;
    @(posedge hclk iff raw_ready === 1'h1);
    expq.push_back(expv(3, acc * 40));
    raw_valid <= 1'h0;
    drain();
    // timer-started sequence over channels 0 and 7
    bwr(8'h0c, 32'h0001_0081, 3'h2);
    trig(1'h0);
    conv(0);
    conv(7);
    poll(8'h0c, 17);
    rchk(8'h0c, 32'h0003_0081);
    `CHK("conversion count", 2, nconv)
    // wrong source ignored, pump clock starts channel 9
    bwr(8'h0c, 32'h0001_0600, 3'h2);
    acc = nconv;
    trig(1'h0);
    repeat (20) @(posedge hclk);
    `CHK("wrong source starts", acc, nconv)
    trig(1'h1);
    conv(9);
    poll(8'h0c, 17);
    bwr(8'h0c, 32'h0000_003f, 3'h2);
    acc = nconv;
    trig(1'h0);
    trig(1'h1);
    repeat (20) @(posedge hclk);
    `CHK("disabled starts", acc, nconv)
    rchk(8'h0c, 32'h0002_003f);
    drain();
    t3();
    rchk(8'h0c, 32'h0);
    rchk(8'h34, model[0]);
    bwr(8'h0c, 32'hffff_ffff, 3'h2);
    rchk(8'h0c, 32'h0001_07ff);
    t3();
    rchk(8'h0c, 32'h0);
    report_and_stop();
  end
endmodule
